/* core/gesture_cfg_defs.vh */
// Register offsets, field positions, reset values and timing counts of the
// gesture gain, drive, wait and offset register bank.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef GESTURE_CFG_DEFS_VH
`define GESTURE_CFG_DEFS_VH

`define ADDR_GAIN_DRIVE_WAIT 8'hA3
`define ADDR_UP_OFFSET 8'hA4
`define ADDR_DOWN_OFFSET 8'hA5
`define ADDR_LEFT_OFFSET 8'hA7
`define ADDR_RIGHT_OFFSET 8'hA9

`define CFG_RESET 8'h00
`define OFFSET_RESET 8'h00
`define CFG_WRITE_MASK 8'h7F

`define GAIN_MSB 6
`define GAIN_LSB 5
`define LED_MSB 4
`define LED_LSB 3
`define WAIT_MSB 2
`define WAIT_LSB 0
`define SIGN_BIT 7

`define CLK_PERIOD_NS 10
`define LED_TAIL_NS 1330
`define LED_TAIL_CYCLES (`LED_TAIL_NS / `CLK_PERIOD_NS)
`define WAIT_UNIT_US 2800
`define WAIT_UNIT_CYCLES ((`WAIT_UNIT_US * 1000) / `CLK_PERIOD_NS)

`define LED_FULL_HALF_MA 8'hC8

`endif

/* core/gesture_offset_store.v */
// Four-entry store of the per-channel crosstalk offset bytes.
// Host read data come out of a register one cycle after the read strobe;
// all four bytes are also presented at once for latching by the core.
module gesture_offset_store (
   input wire clk,
   input wire srst,
   input wire wr_en,
   input wire [1:0] wr_idx,
   input wire [7:0] wr_data,
   input wire [1:0] rd_idx,
   output reg [7:0] rd_data,
   output wire [31:0] all_data
);
`include "gesture_cfg_defs.vh"

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_entry
         localparam [1:0] IDX = g;
         reg [7:0] entry_reg;
         always @(posedge clk) begin
            if (srst) begin
               entry_reg <= `OFFSET_RESET;
            end else if (wr_en && (wr_idx == IDX)) begin
               entry_reg <= wr_data;
            end
         end
         assign all_data[8*g+7:8*g] = entry_reg;
      end
   endgenerate

   always @(posedge clk) begin
      if (srst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= all_data[8*rd_idx +: 8];
      end
   end

endmodule // gesture_offset_store

/* core/gesture_gain_wait_offset_regs.v */
// Gesture gain, LED drive, idle interval and per-channel offset register bank
// with the cycle sequencer that applies them.
// Assumes a register port driven by the serial interface logic on CLK and
// gesture engine status and conversion strobes from logic on the same clock.
//
// Summary of operation
// - Bits 6:5 pick gesture receiver gain 1x, 2x, 4x or 8x.
// - Bits 4:3 pick LED sink current 100, 50, 25 or 12.5 mA.
// - Bits 2:0 pick idle time between cycles, 0 to 39.2 ms.
// - LED stays on about 1.33 us beyond each integration interval.
// - Separate 8-bit offset for up, down, left and right channels.
// - Each offset cancels crosstalk by adding or subtracting its signed factor.
// - Offset bytes are sign/magnitude; bit 7 set means negative, range +-127.
// - Settings are applied only while the gesture engine is running.
`include "gesture_cfg_defs.vh"
module gesture_gain_wait_offset_regs #(
   parameter [22:0] WAIT_UNIT = `WAIT_UNIT_CYCLES
) (
   input wire CLK,
   input wire SRST,
   input wire [7:0] REG_ADDR,
   input wire REG_WE,
   input wire [7:0] REG_WDATA,
   input wire REG_RE,
   output reg [7:0] REG_RDATA,
   output reg REG_RVALID,
   input wire GESTURE_RUNNING,
   input wire INTEG_ACTIVE,
   input wire CYCLE_DONE,
   output reg CYCLE_START,
   output reg LOW_POWER_WAIT,
   output reg SETTINGS_APPLIED,
   output reg [3:0] GAIN_FACTOR,
   output reg [7:0] LED_CURRENT_HALF_MA,
   output reg LED_SINK_EN,
   output reg [7:0] UP_OFFSET_SIGNED,
   output reg [7:0] DOWN_OFFSET_SIGNED,
   output reg [7:0] LEFT_OFFSET_SIGNED,
   output reg [7:0] RIGHT_OFFSET_SIGNED
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ACTIVE = 2'b01;
   localparam [1:0] ST_WAIT = 2'b10;
   localparam [31:0] LED_TAIL_FULL = `LED_TAIL_CYCLES;
   localparam [7:0] LED_TAIL = LED_TAIL_FULL[7:0];

   // Returns {hit, index} of an offset register address.
   function [2:0] offset_decode;
      input [7:0] addr;
      begin
         case (addr)
            `ADDR_UP_OFFSET: offset_decode = 3'b100;
            `ADDR_DOWN_OFFSET: offset_decode = 3'b101;
            `ADDR_LEFT_OFFSET: offset_decode = 3'b110;
            `ADDR_RIGHT_OFFSET: offset_decode = 3'b111;
            default: offset_decode = 3'b000;
         endcase
      end
   endfunction

   // Sign/magnitude to two's complement; all-ones gives -127.
   function [7:0] sm_to_twos;
      input [7:0] sm;
      begin
         if (sm[`SIGN_BIT]) begin
            sm_to_twos = 8'h00 - {1'b0, sm[6:0]};
         end else begin
            sm_to_twos = {1'b0, sm[6:0]};
         end
      end
   endfunction

   // Number of wait units per idle interval code.
   function [3:0] wait_units;
      input [2:0] code;
      begin
         case (code)
            3'h0: wait_units = 4'h0;
            3'h1: wait_units = 4'h1;
            3'h2: wait_units = 4'h2;
            3'h3: wait_units = 4'h3;
            3'h4: wait_units = 4'h5;
            3'h5: wait_units = 4'h8;
            3'h6: wait_units = 4'hB;
            default: wait_units = 4'hE;
         endcase
      end
   endfunction

   reg [7:0] cfg_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [22:0] wait_cnt_reg;
   reg [7:0] tail_cnt_reg;
   reg [2:0] applied_wait_reg;
   reg rd_pend_reg;
   reg rd_cfg_reg;
   reg rd_off_reg;
   reg [7:0] cfg_snap_reg;
   reg latch_now;
   wire [2:0] wr_dec = offset_decode(REG_ADDR);
   wire [7:0] off_rd_data;
   wire [31:0] off_all;

   gesture_offset_store u_offsets (
      .clk(CLK),
      .srst(SRST),
      .wr_en(REG_WE & wr_dec[2]),
      .wr_idx(wr_dec[1:0]),
      .wr_data(REG_WDATA),
      .rd_idx(wr_dec[1:0]),
      .rd_data(off_rd_data),
      .all_data(off_all)
   );

   // Configuration register; reserved bit 7 is held at zero.
   always @(posedge CLK) begin
      if (SRST) begin
         cfg_reg <= `CFG_RESET;
      end else if (REG_WE && REG_ADDR == `ADDR_GAIN_DRIVE_WAIT) begin
         cfg_reg <= REG_WDATA & `CFG_WRITE_MASK;
      end
   end

   // Two-stage read so that offset data leave the store's output register first.
   always @(posedge CLK) begin
      if (SRST) begin
         rd_pend_reg <= 1'b0;
         rd_cfg_reg <= 1'b0;
         rd_off_reg <= 1'b0;
         cfg_snap_reg <= 8'h00;
         REG_RVALID <= 1'b0;
         REG_RDATA <= 8'h00;
      end else begin
         rd_pend_reg <= REG_RE;
         rd_cfg_reg <= REG_RE && REG_ADDR == `ADDR_GAIN_DRIVE_WAIT;
         rd_off_reg <= REG_RE && wr_dec[2];
         cfg_snap_reg <= cfg_reg;
         REG_RVALID <= rd_pend_reg;
         if (rd_cfg_reg) begin
            REG_RDATA <= cfg_snap_reg;
         end else if (rd_off_reg) begin
            REG_RDATA <= off_rd_data;
         end else begin
            REG_RDATA <= 8'h00;
         end
      end
   end

   // Cycle sequencer: conversion, then low-power wait, then the next cycle.
   always @* begin
      state_next = state_reg;
      latch_now = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (GESTURE_RUNNING) begin
               state_next = ST_ACTIVE;
               latch_now = 1'b1;
            end
         end
         ST_ACTIVE: begin
            if (!GESTURE_RUNNING) begin
               state_next = ST_IDLE;
            end else if (CYCLE_DONE) begin
               if (applied_wait_reg == 3'h0) begin
                  latch_now = 1'b1;
               end else begin
                  state_next = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (!GESTURE_RUNNING) begin
               state_next = ST_IDLE;
            end else if (wait_cnt_reg == 23'h1) begin
               state_next = ST_ACTIVE;
               latch_now = 1'b1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge CLK) begin
      if (SRST) begin
         state_reg <= ST_IDLE;
         wait_cnt_reg <= 23'h0;
         applied_wait_reg <= 3'h0;
         CYCLE_START <= 1'b0;
         LOW_POWER_WAIT <= 1'b0;
         SETTINGS_APPLIED <= 1'b0;
         GAIN_FACTOR <= 4'h0;
         LED_CURRENT_HALF_MA <= 8'h00;
         UP_OFFSET_SIGNED <= 8'h00;
         DOWN_OFFSET_SIGNED <= 8'h00;
         LEFT_OFFSET_SIGNED <= 8'h00;
         RIGHT_OFFSET_SIGNED <= 8'h00;
      end else begin
         state_reg <= state_next;
         CYCLE_START <= latch_now;
         LOW_POWER_WAIT <= (state_next == ST_WAIT);
         SETTINGS_APPLIED <= (state_next != ST_IDLE);
         if (state_reg == ST_ACTIVE && state_next == ST_WAIT) begin
            wait_cnt_reg <= WAIT_UNIT * {19'h0, wait_units(applied_wait_reg)};
         end else if (state_reg == ST_WAIT && wait_cnt_reg != 23'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 23'h1;
         end
         // New settings are taken only as a cycle starts, never mid-conversion.
         if (latch_now) begin
            applied_wait_reg <= cfg_reg[`WAIT_MSB:`WAIT_LSB];
            GAIN_FACTOR <= 4'h1 << cfg_reg[`GAIN_MSB:`GAIN_LSB];
            LED_CURRENT_HALF_MA <= `LED_FULL_HALF_MA >> cfg_reg[`LED_MSB:`LED_LSB];
            UP_OFFSET_SIGNED <= sm_to_twos(off_all[7:0]);
            DOWN_OFFSET_SIGNED <= sm_to_twos(off_all[15:8]);
            LEFT_OFFSET_SIGNED <= sm_to_twos(off_all[23:16]);
            RIGHT_OFFSET_SIGNED <= sm_to_twos(off_all[31:24]);
         end else if (state_next == ST_IDLE) begin
            GAIN_FACTOR <= 4'h0;
            LED_CURRENT_HALF_MA <= 8'h00;
            UP_OFFSET_SIGNED <= 8'h00;
            DOWN_OFFSET_SIGNED <= 8'h00;
            LEFT_OFFSET_SIGNED <= 8'h00;
            RIGHT_OFFSET_SIGNED <= 8'h00;
         end
      end
   end

   // LED sink follows integration and holds on for a short tail after it.
   always @(posedge CLK) begin
      if (SRST) begin
         tail_cnt_reg <= 8'h00;
         LED_SINK_EN <= 1'b0;
      end else if (state_reg == ST_IDLE || !GESTURE_RUNNING) begin
         tail_cnt_reg <= 8'h00;
         LED_SINK_EN <= 1'b0;
      end else if (INTEG_ACTIVE) begin
         tail_cnt_reg <= LED_TAIL;
         LED_SINK_EN <= 1'b1;
      end else if (tail_cnt_reg != 8'h00) begin
         tail_cnt_reg <= tail_cnt_reg - 8'h01;
         LED_SINK_EN <= 1'b1;
      end else begin
         LED_SINK_EN <= 1'b0;
      end
   end

endmodule // gesture_gain_wait_offset_regs

/* verification/gesture_regs_properties.sv */
// Port checker for the gesture gain, drive, wait and offset register bank.
// Assumes it is bound to the bank and that every signal lives on CLK.
module gesture_regs_checker #(
   parameter [22:0] WAIT_UNIT = 10
) (
   input wire CLK,
   input wire SRST,
   input wire [7:0] REG_ADDR,
   input wire REG_WE,
   input wire [7:0] REG_WDATA,
   input wire REG_RE,
   input wire REG_RVALID,
   input wire GESTURE_RUNNING,
   input wire INTEG_ACTIVE,
   input wire CYCLE_DONE,
   input wire CYCLE_START,
   input wire LOW_POWER_WAIT,
   input wire SETTINGS_APPLIED,
   input wire [3:0] GAIN_FACTOR,
   input wire [7:0] LED_CURRENT_HALF_MA,
   input wire LED_SINK_EN,
   input wire [7:0] UP_OFFSET_SIGNED
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   reg [7:0] cfg_q, cfg_prev, up_q, up_prev;
   reg [2:0] wait_lat;
   reg [31:0] lp_cnt;
   wire [4:0] units = (wait_lat < 3'h4) ? {2'b00, wait_lat} : 5'd3 * wait_lat - 5'd7;
   function [7:0] s2c(input [7:0] s);
      s2c = s[7] ? 8'h00 - {1'b0, s[6:0]} : {1'b0, s[6:0]};
   endfunction
   // Mirrors of the host writes, delayed one cycle to match the latch edge.
   always @(posedge CLK) begin
      if (SRST) begin
         {cfg_q, cfg_prev, up_q, up_prev, wait_lat, lp_cnt} <= 0;
      end else begin
         if (REG_WE && REG_ADDR == 8'hA3) cfg_q <= REG_WDATA;
         if (REG_WE && REG_ADDR == 8'hA4) up_q <= REG_WDATA;
         cfg_prev <= cfg_q;
         up_prev <= up_q;
         if (CYCLE_START) wait_lat <= cfg_prev[2:0];
         lp_cnt <= LOW_POWER_WAIT ? lp_cnt + 1 : 0;
      end
   end
   a_read_latency: assert property (REG_RE |-> ##2 REG_RVALID)
      else $error("read answer not two cycles after strobe");
   a_gain_code_map: assert property (CYCLE_START |-> GAIN_FACTOR == (4'h1 << cfg_prev[6:5]))
      else $error("gain factor does not match code");
   a_led_code_map: assert property (CYCLE_START |-> LED_CURRENT_HALF_MA == (8'hC8 >> cfg_prev[4:3]))
      else $error("LED current does not match code");
   a_offset_sign_mag: assert property (CYCLE_START |-> UP_OFFSET_SIGNED == s2c(up_prev))
      else $error("offset factor wrong");
   a_idle_clears: assert property (!GESTURE_RUNNING ##1 !GESTURE_RUNNING |-> GAIN_FACTOR == 4'h0 && !SETTINGS_APPLIED)
      else $error("settings applied while not running");
   a_start_on_run: assert property ($rose(GESTURE_RUNNING) && !SETTINGS_APPLIED |=> CYCLE_START)
      else $error("no cycle start after run");
   a_zero_wait_restart: assert property (CYCLE_DONE && SETTINGS_APPLIED && !LOW_POWER_WAIT && !CYCLE_START
      && wait_lat == 3'h0 && GESTURE_RUNNING |=> CYCLE_START || !GESTURE_RUNNING)
      else $error("zero wait did not restart at once");
   a_wait_length: assert property ($fell(LOW_POWER_WAIT) && GESTURE_RUNNING |-> lp_cnt == units * WAIT_UNIT)
      else $error("idle interval length wrong");
   a_led_follows: assert property (INTEG_ACTIVE && GESTURE_RUNNING |=> LED_SINK_EN || !GESTURE_RUNNING)
      else $error("LED off during integration");
   a_led_tail_len: assert property ($fell(INTEG_ACTIVE) && GESTURE_RUNNING |-> ##133
      (LED_SINK_EN || !GESTURE_RUNNING) ##1 !LED_SINK_EN)
      else $error("LED tail length wrong");
   a_hold_in_cycle: assert property (SETTINGS_APPLIED && $past(SETTINGS_APPLIED) && !CYCLE_START
      |-> $stable(GAIN_FACTOR) && $stable(UP_OFFSET_SIGNED))
      else $error("settings changed mid cycle");
   c_wait_done: cover property (LOW_POWER_WAIT ##1 !LOW_POWER_WAIT);
   c_gain_max: cover property (CYCLE_START && GAIN_FACTOR == 4'h8);
   c_led_tail: cover property ($fell(LED_SINK_EN));
endmodule // gesture_regs_checker

bind gesture_gain_wait_offset_regs gesture_regs_checker #(.WAIT_UNIT(WAIT_UNIT)) u_chk (
   .CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_WDATA(REG_WDATA),
   .REG_RE(REG_RE), .REG_RVALID(REG_RVALID), .GESTURE_RUNNING(GESTURE_RUNNING),
   .INTEG_ACTIVE(INTEG_ACTIVE), .CYCLE_DONE(CYCLE_DONE), .CYCLE_START(CYCLE_START),
   .LOW_POWER_WAIT(LOW_POWER_WAIT), .SETTINGS_APPLIED(SETTINGS_APPLIED),
   .GAIN_FACTOR(GAIN_FACTOR), .LED_CURRENT_HALF_MA(LED_CURRENT_HALF_MA),
   .LED_SINK_EN(LED_SINK_EN), .UP_OFFSET_SIGNED(UP_OFFSET_SIGNED));

/* verification/gesture_engine_model.sv */
// Behavioural gesture engine: run flag, integration window and cycle done.
// Assumes the bank's cycle start pulse on the same clock.
module gesture_engine_model (
   input wire clk,
   input wire srst,
   input wire run_req,
   input wire start,
   output logic running,
   output logic integ,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ps;
   int n;
   // The done pulse comes well after the LED tail so tails never overlap.
   always @(posedge clk) begin
      running <= run_req & ~srst;
      done <= 1'b0;
      integ <= run_req && n >= 1 && n < 5;
      if (srst || !run_req) n <= 0;
      else if (start) n <= 1;
      else if (n == 160) begin
         done <= 1'b1;
         n <= 0;
      end else if (n > 0) n <= n + 1;
   end
endmodule // gesture_engine_model

/* verification/tb.sv */
// Self-checking bench of the gesture configuration bank.
// Assumes the bank, its checker and the gesture engine model.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 0, SRST = 1, REG_WE = 0, REG_RE = 0, run = 0;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
   wire [7:0] REG_RDATA, LED_CURRENT_HALF_MA, UP_OFFSET_SIGNED, DOWN_OFFSET_SIGNED;
   wire [7:0] LEFT_OFFSET_SIGNED, RIGHT_OFFSET_SIGNED;
   wire [3:0] GAIN_FACTOR;
   wire REG_RVALID, GESTURE_RUNNING, INTEG_ACTIVE, CYCLE_DONE, CYCLE_START;
   wire LOW_POWER_WAIT, SETTINGS_APPLIED, LED_SINK_EN;
   int fails = 0, comparisons = 0, i, c, n;
   logic [7:0] addrs [5] = '{8'hA3, 8'hA4, 8'hA5, 8'hA7, 8'hA9};
   always #5 CLK = ~CLK;
   gesture_gain_wait_offset_regs #(.WAIT_UNIT(23'd10)) u_gesture_gain_wait_offset_regs (
      .CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_WDATA(REG_WDATA),
      .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
      .GESTURE_RUNNING(GESTURE_RUNNING), .INTEG_ACTIVE(INTEG_ACTIVE), .CYCLE_DONE(CYCLE_DONE),
      .CYCLE_START(CYCLE_START), .LOW_POWER_WAIT(LOW_POWER_WAIT),
      .SETTINGS_APPLIED(SETTINGS_APPLIED), .GAIN_FACTOR(GAIN_FACTOR),
      .LED_CURRENT_HALF_MA(LED_CURRENT_HALF_MA), .LED_SINK_EN(LED_SINK_EN),
      .UP_OFFSET_SIGNED(UP_OFFSET_SIGNED), .DOWN_OFFSET_SIGNED(DOWN_OFFSET_SIGNED),
      .LEFT_OFFSET_SIGNED(LEFT_OFFSET_SIGNED), .RIGHT_OFFSET_SIGNED(RIGHT_OFFSET_SIGNED));
   gesture_engine_model u_gesture_engine_model (.clk(CLK), .srst(SRST), .run_req(run),
      .start(CYCLE_START), .running(GESTURE_RUNNING), .integ(INTEG_ACTIVE), .done(CYCLE_DONE));
   task conclude;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input string s, input logic [7:0] e, input logic [7:0] v);
      comparisons++;
      if (v !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WE <= 1'b1;
      @(posedge CLK);
      REG_WE <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RE <= 1'b1;
      @(posedge CLK);
      REG_RE <= 1'b0;
      @(posedge CLK);
      #1 chk("rvalid", 8'h01, {7'h00, REG_RVALID});
      chk("rdata", e, REG_RDATA);
   endtask
   // Waits for the next cycle start and counts idle cycles on the way.
   task ws;
      i = 0;
      n = 0;
      do begin
         @(posedge CLK);
         #1 n++;
         if (LOW_POWER_WAIT === 1'b1) i++;
      end while (CYCLE_START !== 1'b1 && n < 400);
      if (CYCLE_START !== 1'b1) begin
         fails++;
         conclude;
      end
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      SRST <= 1'b0;
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      foreach (addrs[i]) wr(addrs[i], 8'hFF);
      wr(8'hA6, 8'h55);
      rd(8'hA3, 8'h7F);
      rd(8'hA9, 8'hFF);
      rd(8'hA6, 8'h00);
      $display("test registers done");
      wr(8'hA5, 8'h81);
      wr(8'hA7, 8'h7F);
      wr(8'hA9, 8'h80);
      for (c = 0; c < 8; c++) begin
         wr(8'hA4, 8'hFF);
         wr(8'hA3, {1'b0, c[1:0], c[2:1], c[2:0]});
         run <= 1'b1;
         ws;
         chk("gain", 8'h01 << c[1:0], {4'h0, GAIN_FACTOR});
         chk("led", 8'hC8 >> c[2:1], LED_CURRENT_HALF_MA);
         chk("up", 8'h81, UP_OFFSET_SIGNED);
         chk("down", 8'hFF, DOWN_OFFSET_SIGNED);
         chk("left", 8'h7F, LEFT_OFFSET_SIGNED);
         chk("right", 8'h00, RIGHT_OFFSET_SIGNED);
         chk("applied", 8'h01, {7'h00, SETTINGS_APPLIED});
         wr(8'hA4, 8'h85);
         #1 chk("up held", 8'h81, UP_OFFSET_SIGNED);
         ws;
         chk("wait", (c < 4 ? c : 3 * c - 7) * 10, i);
         chk("up next", 8'hFB, UP_OFFSET_SIGNED);
         @(posedge CLK);
         run <= 1'b0;
         repeat (3) @(posedge CLK);
         #1 chk("gain idle", 8'h00, {4'h0, GAIN_FACTOR});
         chk("applied idle", 8'h00, {7'h00, SETTINGS_APPLIED});
         $display("test cycle %0d done", c);
      end
      conclude;
   end
endmodule // tb
